// ---- hw/lsb_pkg.sv ----
// Package of constants and types for the logic signal bank
package lsb_pkg;
  localparam int NUM_IN = 32;
  localparam int NUM_OUT = 64;
  localparam int NUM_SIG = NUM_IN + NUM_OUT;
  localparam int IDX_W = 7;
  localparam int TS_W = 32;
  localparam int CNT_W = 18;
  localparam int CLK_HZ = 50_000_000;
  localparam int PULSE_US = 5_000;
  // Fixed pulse length in cycles, 5 ms at the clock rate
  localparam int PULSE_CYC = (CLK_HZ / 1_000_000) * PULSE_US;
  localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
  localparam logic [TS_W-1:0] TS_ONE = 32'h00000001;
  // Event storage selection
  typedef enum logic [1:0] {
    LSB_SEL_NONE = 2'b00,
    LSB_SEL_ON = 2'b01,
    LSB_SEL_OFF = 2'b10,
    LSB_SEL_BOTH = 2'b11
  } lsb_sel_t;
endpackage : lsb_pkg

// ---- hw/lsb_pick.sv ----
// Lowest-index picker over a request vector
`timescale 1ns/100ps
`default_nettype none
module lsb_pick #(
  parameter int N = 192,
  parameter int W = 8
) (
  // Requests
  input wire logic [N-1:0] req,
  // Result
  output logic found,
  output logic [W-1:0] idx
);
  initial begin
    if (N > (1 << W)) begin
      $error("lsb_pick: index too narrow");
    end
  end

  // Scan downward so the lowest request wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : lsb_pick
`default_nettype wire

// ---- hw/lsb_bank.sv ----
// Logic signal bank: command inputs, logic outputs and event reporting
// Functional notes
// - Thirty-two inputs set by link or panel
// - Inputs clear to zero after every reboot
// - Hold mode keeps one until zero command
// - Pulse mode returns to zero after 5 ms
// - Sixty-four outputs driven from user logic
// - Outputs raise ON and OFF events
// - Setting selects ON, OFF or both stored
// - Each event carries its change time stamp
`timescale 1ns/100ps
`default_nettype none
module lsb_bank #(
  parameter int PULSE_CYCLES = lsb_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Supervisory link command
  input wire logic LINK_CMD_VALID,
  input wire logic [4:0] LINK_CMD_INDEX,
  input wire logic LINK_CMD_VALUE,
  // Panel switch command
  input wire logic PANEL_CMD_VALID,
  input wire logic [4:0] PANEL_CMD_INDEX,
  input wire logic PANEL_CMD_VALUE,
  // Configuration
  input wire logic [31:0] PULSE_MODE,
  input wire logic [1:0] EVENT_SELECT,
  // User logic
  input wire logic [63:0] LOGIC_RESULT,
  // Status
  output logic [31:0] IN_STATUS,
  output logic [63:0] OUT_STATUS,
  // Event stream
  output logic EVT_VALID,
  output logic [6:0] EVT_INDEX,
  output logic EVT_ON,
  output logic [31:0] EVT_TIME
);
  localparam int NI = lsb_pkg::NUM_IN;
  localparam int NS = lsb_pkg::NUM_SIG;
  localparam int CW = lsb_pkg::CNT_W;
  localparam int TW = lsb_pkg::TS_W;
  localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYCLES);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << CW)) begin
      $error("lsb_bank: PULSE_CYCLES out of range");
    end
  end

  typedef struct packed {
    logic [NI-1:0] in_st;
    logic [lsb_pkg::NUM_OUT-1:0] out_st;
    logic [NI-1:0][CW-1:0] cnt;
    logic [NS-1:0] pend_on;
    logic [NS-1:0] pend_off;
    logic [NS-1:0][TW-1:0] ts;
    logic [TW-1:0] now;
    logic evt_valid;
    logic [lsb_pkg::IDX_W-1:0] evt_index;
    logic evt_on;
    logic [TW-1:0] evt_time;
  } lsb_state_t;

  lsb_state_t s_q;
  lsb_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic pick_found;
  logic [7:0] pick_idx;
  logic sel_on;
  logic sel_off;

  // Reset released through two flops; async assert, sync release.
  // Kept out of the state struct: it has its own reset and process
  always_ff @(posedge CLK or negedge RESET_N) begin : p_rst
    if (!RESET_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Offered events, OFF group above ON group
  lsb_pick #(
    .N(2 * NS),
    .W(8)
  ) u_pick (
    .req({s_q.pend_off, s_q.pend_on}),
    .found(pick_found),
    .idx(pick_idx)
  );

  assign sel_on = EVENT_SELECT[0];
  assign sel_off = EVENT_SELECT[1];

  // Next state of the whole bank
  always_comb begin : p_next
    logic [NS-1:0] cur_v;
    logic [NS-1:0] nxt_v;
    cur_v = {s_q.out_st, s_q.in_st};
    nxt_v = cur_v;
    s_d = s_q;
    s_d.now = s_q.now + lsb_pkg::TS_ONE;
    // Outputs follow user logic one cycle later
    s_d.out_st = LOGIC_RESULT;
    for (int i = 0; i < NI; i++) begin
      // Pulse timer runs down; reaching zero ends the pulse
      if (s_q.cnt[i] != lsb_pkg::CNT_ZERO) begin
        s_d.cnt[i] = s_q.cnt[i] - lsb_pkg::CNT_ONE;
        if (s_q.cnt[i] == lsb_pkg::CNT_ONE) begin
          s_d.in_st[i] = 1'b0;
        end
      end
      // Link command wins over a panel command to the same input
      if ((LINK_CMD_VALID && LINK_CMD_INDEX == 5'(i)) ||
          (PANEL_CMD_VALID && PANEL_CMD_INDEX == 5'(i))) begin
        if (LINK_CMD_VALID && LINK_CMD_INDEX == 5'(i)) begin
          s_d.in_st[i] = LINK_CMD_VALUE;
        end else begin
          s_d.in_st[i] = PANEL_CMD_VALUE;
        end
        // Hold mode leaves the timer idle; a one stays until zero
        if (PULSE_MODE[i] && s_d.in_st[i]) begin
          s_d.cnt[i] = PULSE_LOAD;
        end else begin
          s_d.cnt[i] = lsb_pkg::CNT_ZERO;
        end
      end
    end
    // Hand out one pending event per cycle
    s_d.evt_valid = pick_found;
    s_d.evt_index = pick_idx[lsb_pkg::IDX_W-1:0];
    s_d.evt_on = 1'b0;
    s_d.evt_time = s_q.evt_time;
    if (pick_found) begin
      if (pick_idx < 8'(NS)) begin
        s_d.evt_on = 1'b1;
        s_d.pend_on[pick_idx[6:0]] = 1'b0;
        s_d.evt_time = s_q.ts[pick_idx[6:0]];
      end else begin
        s_d.evt_index = 7'(pick_idx - 8'(NS));
        s_d.pend_off[7'(pick_idx - 8'(NS))] = 1'b0;
        s_d.evt_time = s_q.ts[7'(pick_idx - 8'(NS))];
      end
    end
    // A fresh change after the clear above wins and restamps; the
    // change vector is built here so no loop runs back through s_d
    nxt_v = {s_d.out_st, s_d.in_st};
    for (int k = 0; k < NS; k++) begin
      if (nxt_v[k] != cur_v[k]) begin
        s_d.ts[k] = s_q.now;
        if (nxt_v[k]) begin
          s_d.pend_on[k] = sel_on;
          s_d.pend_off[k] = 1'b0;
        end else begin
          s_d.pend_off[k] = sel_off;
          s_d.pend_on[k] = 1'b0;
        end
      end
    end
  end

  // Everything but the reset synchroniser; reboot clears all state
  always_ff @(posedge CLK or negedge rst_n) begin : p_state
    if (!rst_n) begin
      s_q.in_st <= '0;
      s_q.out_st <= '0;
      s_q.cnt <= '0;
      s_q.pend_on <= '0;
      s_q.pend_off <= '0;
      s_q.ts <= '0;
      s_q.now <= '0;
      s_q.evt_valid <= 1'b0;
      s_q.evt_index <= '0;
      s_q.evt_on <= 1'b0;
      s_q.evt_time <= '0;
    end else begin
      s_q.in_st <= s_d.in_st;
      s_q.out_st <= s_d.out_st;
      s_q.cnt <= s_d.cnt;
      s_q.pend_on <= s_d.pend_on;
      s_q.pend_off <= s_d.pend_off;
      s_q.ts <= s_d.ts;
      s_q.now <= s_d.now;
      s_q.evt_valid <= s_d.evt_valid;
      s_q.evt_index <= s_d.evt_index;
      s_q.evt_on <= s_d.evt_on;
      s_q.evt_time <= s_d.evt_time;
    end
  end

  // Ports straight from flops
  assign IN_STATUS = s_q.in_st;
  assign OUT_STATUS = s_q.out_st;
  assign EVT_VALID = s_q.evt_valid;
  assign EVT_INDEX = s_q.evt_index;
  assign EVT_ON = s_q.evt_on;
  assign EVT_TIME = s_q.evt_time;

  // Checks on the bank behaviour
  a_reboot_clear: assert property (@(posedge CLK)
    $rose(rst_n) |-> IN_STATUS == '0)
    else $error("inputs not zero after reboot");
  a_link_sets: assert property (@(posedge CLK)
    disable iff (!rst_n)
    LINK_CMD_VALID |=> IN_STATUS[$past(LINK_CMD_INDEX)] ==
      $past(LINK_CMD_VALUE))
    else $error("link command not applied");
  a_hold_stays: assert property (@(posedge CLK)
    disable iff (!rst_n)
    (IN_STATUS[0] && !PULSE_MODE[0] && s_q.cnt[0] == '0 &&
     !(LINK_CMD_VALID && LINK_CMD_INDEX == 5'h00) &&
     !(PANEL_CMD_VALID && PANEL_CMD_INDEX == 5'h00)) |=> IN_STATUS[0])
    else $error("held input dropped");
  a_pulse_ends: assert property (@(posedge CLK)
    disable iff (!rst_n)
    (s_q.cnt[0] == lsb_pkg::CNT_ONE &&
     !(LINK_CMD_VALID && LINK_CMD_INDEX == 5'h00) &&
     !(PANEL_CMD_VALID && PANEL_CMD_INDEX == 5'h00)) |=> !IN_STATUS[0])
    else $error("pulse did not end");
  a_pulse_load: assert property (@(posedge CLK)
    disable iff (!rst_n)
    (LINK_CMD_VALID && LINK_CMD_VALUE && PULSE_MODE[LINK_CMD_INDEX])
      |=> s_q.cnt[$past(LINK_CMD_INDEX)] == PULSE_LOAD)
    else $error("pulse timer not loaded");
  // Sampled rst_n keeps the edge that still holds reset out of the check
  a_out_follow: assert property (@(posedge CLK)
    disable iff (!rst_n)
    rst_n |=> OUT_STATUS == $past(LOGIC_RESULT))
    else $error("output status lags user logic");
  a_out_event: assert property (@(posedge CLK)
    disable iff (!rst_n)
    ($rose(OUT_STATUS[0]) && EVENT_SELECT == lsb_pkg::LSB_SEL_BOTH)
      |-> ##[1:200] (EVT_VALID && EVT_INDEX == 7'h20))
    else $error("output event missing");
  // No pending flag may be newly raised while nothing is selected
  a_evt_select: assert property (@(posedge CLK)
    disable iff (!rst_n)
    $past(EVENT_SELECT) == lsb_pkg::LSB_SEL_NONE |->
      (((s_q.pend_on | s_q.pend_off) &
        ~($past(s_q.pend_on) | $past(s_q.pend_off))) == '0))
    else $error("event stored while none selected");
  a_evt_time: assert property (@(posedge CLK)
    disable iff (!rst_n)
    EVT_VALID |-> EVT_TIME < s_q.now)
    else $error("event stamp not in the past");
  a_in_event: assert property (@(posedge CLK)
    disable iff (!rst_n)
    ($fell(IN_STATUS[0]) && EVENT_SELECT == lsb_pkg::LSB_SEL_BOTH)
      |-> ##[1:200] (EVT_VALID && EVT_INDEX == 7'h00 && !EVT_ON))
    else $error("input OFF event missing");
endmodule : lsb_bank
`default_nettype wire

// ---- testbench/lsb_far.sv ----
// Partner model: supervisory link and user logic
`timescale 1ns/100ps
`default_nettype none
module lsb_far (
  // Clock
  input wire logic clk,
  // Link command
  output logic cmd_valid,
  output logic [4:0] cmd_index,
  output logic cmd_value,
  // User logic
  output logic [63:0] result
);
  initial begin
    cmd_valid = 1'b0;
    cmd_index = 5'h00;
    cmd_value = 1'b0;
    result = 64'h0;
  end
  // One-cycle command; idle lines show the inverse so stale data is useless
  task send(input logic [4:0] idx, input logic val);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_index = idx;
    cmd_value = val;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_index = ~idx;
    cmd_value = ~val;
  endtask : send
  // User logic result; the bench calls this just after a falling edge
  task put(input logic [63:0] v);
    result = v;
  endtask : put
endmodule : lsb_far
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the logic signal bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int P = 20;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic pv = 1'b0;
  logic [4:0] pi = 5'h00;
  logic pval = 1'b0;
  logic [31:0] pmode = 32'h0;
  logic [1:0] sel = 2'h3;
  logic lv, lval;
  logic [4:0] li;
  logic [63:0] res, outs;
  logic [31:0] ins, etime, ev_time;
  logic ev, eon, ev_on;
  logic [6:0] eidx, ev_idx;
  int errors = 0;
  int cmp_count = 0;
  int ev_n = 0;
  int cyc = 0;
  int t0;
  lsb_far far_u (.clk(CLK), .cmd_valid(lv), .cmd_index(li),
    .cmd_value(lval), .result(res));
  lsb_bank #(.PULSE_CYCLES(P)) dut_u (.CLK(CLK), .RESET_N(RESET_N),
    .LINK_CMD_VALID(lv), .LINK_CMD_INDEX(li), .LINK_CMD_VALUE(lval),
    .PANEL_CMD_VALID(pv), .PANEL_CMD_INDEX(pi), .PANEL_CMD_VALUE(pval),
    .PULSE_MODE(pmode), .EVENT_SELECT(sel), .LOGIC_RESULT(res),
    .IN_STATUS(ins), .OUT_STATUS(outs), .EVT_VALID(ev),
    .EVT_INDEX(eidx), .EVT_ON(eon), .EVT_TIME(etime));
  initial begin
    forever #10 CLK = ~CLK;
  end
  // Latest event seen, plus a cycle count; also cuts a hang short
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (ev === 1'b1) begin
      ev_n <= ev_n + 1;
      ev_idx <= eidx;
      ev_on <= eon;
      ev_time <= etime;
    end
    if (cyc == 1000) begin
      errors++;
      final_report();
    end
  end
  task chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge CLK);
  endtask : wt
  task boot();
    RESET_N = 1'b0;
    wt(3);
    RESET_N = 1'b1;
    wt(4);
  endtask : boot
  task t_hold();
    far_u.send(5'h00, 1'b1);
    chk(ins[0], 1'b1);
    wt(30);
    chk(ins[0], 1'b1);
    chk({ev_idx, ev_on}, {7'h00, 1'b1});
    far_u.send(5'h00, 1'b0);
    chk(ins[0], 1'b0);
    wt(3);
    chk({ev_idx, ev_on}, {7'h00, 1'b0});
    $display("hold test done");
  endtask : t_hold
  task t_pulse();
    pmode[3] = 1'b1;
    pv = 1'b1;
    pi = 5'h03;
    pval = 1'b1;
    @(negedge CLK);
    pv = 1'b0;
    pi = 5'h1c;
    pval = 1'b0;
    chk(ins[3], 1'b1);
    wt(P - 1);
    chk(ins[3], 1'b1);
    wt(1);
    chk(ins[3], 1'b0);
    wt(3);
    chk({ev_idx, ev_on}, {7'h03, 1'b0});
    // Link pulse on input 0, then a pulse cut short by a zero command
    pmode[0] = 1'b1;
    far_u.send(5'h00, 1'b1);
    chk(ins[0], 1'b1);
    wt(P - 1);
    chk(ins[0], 1'b1);
    wt(1);
    chk(ins[0], 1'b0);
    far_u.send(5'h00, 1'b1);
    far_u.send(5'h00, 1'b0);
    chk(ins[0], 1'b0);
    pmode[0] = 1'b0;
    $display("pulse test done");
  endtask : t_pulse
  task t_out();
    far_u.put(64'h8000_0000_0000_0000);
    t0 = cyc;
    wt(4);
    chk(outs, 64'h8000_0000_0000_0000);
    chk({ev_idx, ev_on}, {7'h5f, 1'b1});
    far_u.put(64'h0000_0000_0000_0000);
    t0 = cyc - t0;
    wt(4);
    chk({ev_idx, ev_on}, {7'h5f, 1'b0});
    t0 = ev_time - t0;
    // Two rises at once: lowest index reported first, same stamp
    far_u.put(64'h8000_0000_0000_0001);
    wt(4);
    chk(ev_time, t0[31:0] + 32'h8);
    chk({ev_idx, ev_on}, {7'h5f, 1'b1});
    // ON only: the OFF of bit 63 is dropped, the ON of bit 1 kept
    sel = 2'h1;
    t0 = ev_n;
    far_u.put(64'h0000_0000_0000_0001);
    wt(4);
    far_u.put(64'h0000_0000_0000_0003);
    wt(4);
    chk(ev_n, t0 + 1);
    chk({ev_idx, ev_on}, {7'h21, 1'b1});
    // OFF only: the OFF of bit 0 kept, the ON of bit 2 dropped
    sel = 2'h2;
    t0 = ev_n;
    far_u.put(64'h0000_0000_0000_0002);
    wt(4);
    far_u.put(64'h0000_0000_0000_0006);
    wt(4);
    chk(ev_n, t0 + 1);
    chk({ev_idx, ev_on}, {7'h20, 1'b0});
    // Nothing selected: no change is stored
    sel = 2'h0;
    t0 = ev_n;
    far_u.put(64'h0000_0000_0000_0000);
    wt(4);
    far_u.put(64'h0000_0000_0000_0001);
    wt(4);
    chk(ev_n, t0);
    sel = 2'h3;
    $display("output test done");
  endtask : t_out
  task final_report();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial begin
    boot();
    chk({ins, outs}, 96'h0);
    t_hold();
    t_pulse();
    t_out();
    // Reboot with an input held high and user logic active
    far_u.send(5'h07, 1'b1);
    chk(ins[7], 1'b1);
    boot();
    chk(ins, 32'h0);
    chk(outs, 64'h0000_0000_0000_0001);
    $display("reboot test done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
